// File: hw/hid_iso_engine.sv
// Isochronous descriptor engine with register port and interrupt
//
// The strobed register port and the address map were decided locally.
`timescale 1ns/10ps
module hid_iso_engine (
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic [11:0] reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_write_in,
    input  wire logic        reg_read_in,
    output logic      [31:0] reg_rdata_out,
    output logic             irq_out,
    input  wire logic [10:0] usb_frame_in,
    input  wire logic [2:0]  usb_uframe_in,
    input  wire logic        usb_usof_in,
    output logic             txn_start_out,
    output logic             txn_is_in_out,
    output logic             busy_out,
    output logic             out_valid_out,
    output logic      [31:0] out_data_out,
    input  wire logic        out_ready_in,
    input  wire logic        in_valid_in,
    input  wire logic [31:0] in_data_in,
    input  wire logic        txn_done_in,
    input  wire logic [10:0] txn_bytes_in,
    input  wire logic        txn_err_in,
    input  wire logic        txn_babble_in,
    input  wire logic        txn_underrun_in,
    input  wire logic        txn_stall_in
);
    import hid_pkg::*;

    typedef struct packed {
        hid_state_type   state;
        logic [7:0][31:0] dw;
        logic [2:0]      uf;
        logic            is_in;
        logic            start;
        logic [15:0]     ptr;
        logic [31:0]     rd;
        logic            sel_mem;
        logic [2:0]      irq_status;
        logic [2:0]      irq_mask;
    } hid_eng_type;

    hid_eng_type                st_r;
    hid_eng_type                st_nxt;
    logic                       mem_we;
    logic                       mem_re;
    logic [PAYLOAD_AW-1:0]      mem_addr;
    logic [31:0]                mem_wdata;
    logic [31:0]                mem_rdata;
    logic                       busy;
    logic                       in_window;
    logic                       launch;
    logic [2:0]                 code;
    logic [2:0]                 irq_set;
    logic [1:0]                 token;

    hid_payload_mem i_hid_payload_mem (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .we_in       (mem_we),
        .re_in       (mem_re),
        .addr_in     (mem_addr),
        .wdata_in    (mem_wdata),
        .rdata_out   (mem_rdata)
    );

    assign busy      = st_r.state != HID_IDLE;
    assign in_window = (reg_addr_in >= PAYLOAD_BASE) && (reg_addr_in < PAYLOAD_END);
    assign token     = st_r.dw[DW_TOKEN][TOKEN_LSB +: 2];
    // Launch gate: active, not halted, frame match, mask bit set
    assign launch    = !busy && usb_usof_in
                     && st_r.dw[DW_STATE][ACTIVE_BIT] && !st_r.dw[DW_STATE][HALT_BIT]
                     && frame_match(st_r.dw[DW_BUF], usb_frame_in)
                     && st_r.dw[DW_RESULT][usb_uframe_in]
                     && (token == TOKEN_OUT || token == TOKEN_IN);

    always_comb begin
        st_nxt       = st_r;
        st_nxt.start = 1'b0;
        st_nxt.rd    = 32'h0000_0000;
        st_nxt.sel_mem = 1'b0;
        mem_we       = 1'b0;
        mem_re       = 1'b0;
        mem_addr     = buf_addr(st_r.dw[DW_BUF][START_LSB +: 16], st_r.ptr);
        mem_wdata    = in_data_in;
        irq_set      = IRQ_RESET;
        code         = 3'h0;

        // Software writes
        if (reg_write_in) begin
            if (reg_addr_in <= REG_DW7 && reg_addr_in[1:0] == 2'h0) begin
                case (reg_addr_in[4:2])
                    DW_BUF: begin
                        st_nxt.dw[DW_BUF] = reg_wdata_in & DW2_WMASK;
                        st_nxt.ptr        = 16'h0000;
                    end
                    DW_STATE: begin
                        st_nxt.dw[DW_STATE] = reg_wdata_in & DW3_WMASK;
                    end
                    default: begin
                        st_nxt.dw[reg_addr_in[4:2]] = reg_wdata_in;
                    end
                endcase
            end else if (reg_addr_in == REG_IRQ_MASK) begin
                st_nxt.irq_mask = reg_wdata_in[2:0];
            end else if (in_window && !busy) begin
                mem_we    = 1'b1;
                mem_addr  = reg_addr_in[PAYLOAD_AW+1:2];
                mem_wdata = reg_wdata_in;
            end
        end

        // Software reads, answered in the next cycle
        if (reg_read_in) begin
            if (reg_addr_in <= REG_DW7 && reg_addr_in[1:0] == 2'h0) begin
                st_nxt.rd = st_r.dw[reg_addr_in[4:2]];
            end else if (reg_addr_in == REG_IRQ_STATUS) begin
                st_nxt.rd = {29'h0000_0000, st_r.irq_status};
            end else if (reg_addr_in == REG_IRQ_MASK) begin
                st_nxt.rd = {29'h0000_0000, st_r.irq_mask};
            end else if (in_window && !busy) begin
                mem_re         = 1'b1;
                mem_addr       = reg_addr_in[PAYLOAD_AW+1:2];
                st_nxt.sel_mem = 1'b1;
            end
        end

        // Transaction engine
        case (st_r.state)
            HID_IDLE: begin
                if (launch) begin
                    st_nxt.is_in = token == TOKEN_IN;
                    st_nxt.uf    = usb_uframe_in;
                    st_nxt.start = 1'b1;
                    st_nxt.state = (token == TOKEN_IN) ? HID_RECV : HID_FETCH;
                end
            end
            HID_FETCH: begin
                mem_re       = 1'b1;
                st_nxt.state = HID_SEND;
            end
            HID_SEND: begin
                if (out_ready_in) begin
                    st_nxt.ptr   = st_r.ptr + 16'h0001;
                    st_nxt.state = HID_FETCH;
                end
            end
            HID_RECV: begin
                if (in_valid_in) begin
                    mem_we     = 1'b1;
                    st_nxt.ptr = st_r.ptr + 16'h0001;
                end
            end
            default: begin
                st_nxt.state = HID_IDLE;
            end
        endcase

        // Write-back at end of the microframe transaction
        if (busy && txn_done_in) begin
            code[CODE_ERR]      = txn_err_in;
            code[CODE_BABBLE]   = st_r.is_in && txn_babble_in;
            code[CODE_UNDERRUN] = !st_r.is_in && txn_underrun_in;
            st_nxt.dw[DW_RESULT][RESULT_LSB + 3 * st_r.uf +: 3] = code;
            if (!(reg_write_in && reg_addr_in == {REG_DW0[11:5], DW_RESULT, 2'h0})) begin
                st_nxt.dw[DW_RESULT][st_r.uf] = 1'b0;
            end
            st_nxt.dw[DW_STATE][14:0] =
                count_add(st_r.dw[DW_STATE][14:0], txn_bytes_in);
            if (txn_stall_in) begin
                st_nxt.dw[DW_STATE][HALT_BIT]   = 1'b1;
                st_nxt.dw[DW_STATE][ACTIVE_BIT] = 1'b0;
                irq_set[IRQ_HALT]               = 1'b1;
            end
            irq_set[IRQ_DONE] = 1'b1;
            irq_set[IRQ_ERR]  = |code;
            st_nxt.state      = HID_IDLE;
        end

        // Read clears status; a new event in the same cycle survives
        if (reg_read_in && reg_addr_in == REG_IRQ_STATUS) begin
            st_nxt.irq_status = irq_set;
        end else begin
            st_nxt.irq_status = st_r.irq_status | irq_set;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_out = st_r.sel_mem ? mem_rdata : st_r.rd;
    assign irq_out       = |(st_r.irq_status & st_r.irq_mask);
    assign txn_start_out = st_r.start;
    assign txn_is_in_out = st_r.is_in;
    assign busy_out      = busy;
    assign out_valid_out = st_r.state == HID_SEND;
    assign out_data_out  = mem_rdata;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    logic done_ok;
    assign done_ok = busy && txn_done_in && !reg_write_in;

    sequence s_armed;
        usb_usof_in && !busy && st_r.dw[DW_STATE][ACTIVE_BIT]
            && !st_r.dw[DW_STATE][HALT_BIT] && st_r.dw[DW_RESULT][usb_uframe_in]
            && (token == TOKEN_OUT || token == TOKEN_IN);
    endsequence

    sequence s_started;
        txn_start_out && busy;
    endsequence

    sequence s_offer_taken;
        out_valid_out && out_ready_in;
    endsequence

    a_start_needs_active: assert property (
        txn_start_out |-> $past(st_r.dw[DW_STATE][ACTIVE_BIT] && !st_r.dw[DW_STATE][HALT_BIT]))
        else $error("transaction started for inactive or halted descriptor");

    a_frame_gate: assert property (
        txn_start_out |-> $past(usb_frame_in[4:0] == st_r.dw[DW_BUF][FRAME_MSB:FRAME_LSB]))
        else $error("transaction started on wrong frame");

    a_low_bits_ignored: assert property (
        s_armed and (usb_frame_in[4:0] == st_r.dw[DW_BUF][FRAME_MSB:FRAME_LSB]) |=> s_started)
        else $error("matching frame did not start a transaction");

    a_mask_gate: assert property (
        txn_start_out |-> $past(st_r.dw[DW_RESULT][usb_uframe_in]))
        else $error("transaction started with mask bit clear");

    a_mask_cleared: assert property (
        done_ok |=> !st_r.dw[DW_RESULT][st_r.uf] && !busy)
        else $error("mask bit not cleared after microframe");

    a_halt_stall: assert property (
        done_ok && txn_stall_in |=> st_r.dw[DW_STATE][HALT_BIT]
            && !st_r.dw[DW_STATE][ACTIVE_BIT] ##1 !txn_start_out)
        else $error("stall did not halt descriptor");

    a_babble_zero: assert property (
        !st_r.dw[DW_STATE][BABBLE_BIT])
        else $error("descriptor babble bit set");

    a_result_code: assert property (
        done_ok |=> code_get(st_r.dw[DW_RESULT], st_r.uf) ==
            {$past(!st_r.is_in && txn_underrun_in), $past(st_r.is_in && txn_babble_in),
             $past(txn_err_in)})
        else $error("microframe result code wrong");

    a_count_update: assert property (
        done_ok |=> st_r.dw[DW_STATE][14:0] ==
            count_add($past(st_r.dw[DW_STATE][14:0]), $past(txn_bytes_in)))
        else $error("byte count not updated");

    a_irq_level: assert property (
        busy && txn_done_in && !(reg_read_in && reg_addr_in == REG_IRQ_STATUS)
            && st_r.irq_mask[IRQ_DONE] |=> irq_out)
        else $error("done event did not raise interrupt");

    a_token_gate: assert property (
        txn_start_out |-> $past(token == TOKEN_OUT || token == TOKEN_IN))
        else $error("transaction started with unsupported token");

    a_dir_latched: assert property (
        txn_start_out |-> txn_is_in_out == $past(token == TOKEN_IN))
        else $error("transaction direction does not follow token");

    a_skip_inactive: assert property (
        !busy && !(st_r.dw[DW_STATE][ACTIVE_BIT] && !st_r.dw[DW_STATE][HALT_BIT]) |=> !txn_start_out)
        else $error("inactive or halted descriptor launched");

    a_start_pulse: assert property (
        txn_start_out |=> !txn_start_out)
        else $error("start pulse longer than one cycle");

    a_out_fetch_gap: assert property (
        s_offer_taken |=> !out_valid_out)
        else $error("no fetch gap after accepted word");

    a_out_hold: assert property (
        out_valid_out && !out_ready_in && !txn_done_in |=> out_valid_out && $stable(out_data_out))
        else $error("offered word not held until accepted");

    a_rdata_idle: assert property (
        !$past(reg_read_in) |-> reg_rdata_out == 32'h0000_0000)
        else $error("read data not zero outside answer cycle");

    a_irq_clear: assert property (
        reg_read_in && reg_addr_in == REG_IRQ_STATUS && !(busy && txn_done_in) |=> st_r.irq_status == IRQ_RESET)
        else $error("status read did not clear interrupt status");
endmodule

// File: hw/hid_pkg.sv
// Constants, types and helpers for the isochronous descriptor handler
// How it works
// - Result code: bit 0 transaction error, bit 1 babble (IN), bit 2 underrun (OUT).
// - Software sets activity mask bits; hardware clears each after its microframe runs, unless software writes the DW_RESULT word in that cycle.
// - Activity mask is checked only when descriptor frame bits 7..3 match bus frame.
// - Frame field bits 2..0 are ignored in the frame match.
// - Stall sets the single halt bit and clears the active bit.
// - Descriptor babble bit is unused and always reads zero.
// - Hardware writes bytes moved into the fifteen-bit byte count.
// - With several packets the byte count may hold partial sums between packets.
// - One descriptor moves at most 32 kbytes; the count saturates.
// - Each microframe has a three-bit result code, microframe seven at the top.
// - Token 00 means OUT, 01 means IN; it selects which error bits apply.
package hid_pkg;

    // Register byte offsets
    localparam logic [11:0] REG_DW0          = 12'h000;
    localparam logic [11:0] REG_DW7          = 12'h01C;
    localparam logic [11:0] REG_IRQ_STATUS   = 12'h020;
    localparam logic [11:0] REG_IRQ_MASK     = 12'h024;
    localparam logic [11:0] PAYLOAD_BASE     = 12'h400;
    localparam logic [11:0] PAYLOAD_END      = 12'h800;

    // Payload buffer geometry
    localparam int          PAYLOAD_AW       = 8;
    localparam int          PAYLOAD_DEPTH    = 256;

    // Descriptor word indices
    localparam logic [2:0]  DW_TOKEN         = 3'h1;
    localparam logic [2:0]  DW_BUF           = 3'h2;
    localparam logic [2:0]  DW_STATE         = 3'h3;
    localparam logic [2:0]  DW_RESULT        = 3'h4;

    // Field positions
    localparam int          TOKEN_LSB        = 10;
    localparam int          FRAME_MSB        = 7;
    localparam int          FRAME_LSB        = 3;
    localparam int          START_LSB        = 8;
    localparam int          ACTIVE_BIT       = 31;
    localparam int          HALT_BIT         = 30;
    localparam int          BABBLE_BIT       = 29;
    localparam int          RESULT_LSB       = 8;
    localparam int          CODE_ERR         = 0;
    localparam int          CODE_BABBLE      = 1;
    localparam int          CODE_UNDERRUN    = 2;

    // Writable bits; reserved and babble bits read zero
    localparam logic [31:0] DW2_WMASK        = 32'h00FF_FFFF;
    localparam logic [31:0] DW3_WMASK        = 32'hC000_7FFF;

    // Reset values
    localparam logic [31:0] DW_RESET         = 32'h0000_0000;
    localparam logic [2:0]  IRQ_RESET        = 3'h0;

    localparam logic [1:0]  TOKEN_OUT        = 2'h0;
    localparam logic [1:0]  TOKEN_IN         = 2'h1;
    localparam logic [14:0] COUNT_MAX        = 15'h7FFF;

    // Interrupt event bits
    localparam int          IRQ_DONE         = 0;
    localparam int          IRQ_HALT         = 1;
    localparam int          IRQ_ERR          = 2;

    typedef enum logic [1:0] {
        HID_IDLE  = 2'b00,
        HID_FETCH = 2'b01,
        HID_SEND  = 2'b10,
        HID_RECV  = 2'b11
    } hid_state_type;

    function automatic logic frame_match(input logic [31:0] dw2, input logic [10:0] frame);
        return dw2[FRAME_MSB:FRAME_LSB] == frame[FRAME_MSB-FRAME_LSB:0];
    endfunction

    function automatic logic [2:0] code_get(input logic [31:0] dw4, input logic [2:0] uf);
        return dw4[RESULT_LSB + 3 * uf +: 3];
    endfunction

    function automatic logic [14:0] count_add(input logic [14:0] c, input logic [10:0] b);
        logic [15:0] s;
        s = {1'b0, c} + {5'h00, b};
        return s[15] ? COUNT_MAX : s[14:0];
    endfunction

    function automatic logic [PAYLOAD_AW-1:0] buf_addr(input logic [15:0] start,
                                                       input logic [15:0] ptr);
        logic [15:0] s;
        // Start counts eight-byte units; payload words are four bytes
        s = {start[14:0], 1'b0} + ptr;
        return s[PAYLOAD_AW-1:0];
    endfunction

endpackage

// File: hw/hid_payload_mem.sv
// Payload buffer memory with registered read data
`timescale 1ns/10ps
module hid_payload_mem (
    input  wire logic                           core_clk_in,
    input  wire logic                           rst_in,
    input  wire logic                           we_in,
    input  wire logic                           re_in,
    input  wire logic [hid_pkg::PAYLOAD_AW-1:0] addr_in,
    input  wire logic [31:0]                    wdata_in,
    output logic      [31:0]                    rdata_out
);
    import hid_pkg::*;

    typedef struct packed {
        logic [PAYLOAD_DEPTH-1:0][31:0] mem;
        logic [31:0]                    rdata;
    } hid_mem_type;

    hid_mem_type st_r;
    hid_mem_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (we_in) begin
            st_nxt.mem[addr_in] = wdata_in;
        end
        if (re_in) begin
            st_nxt.rdata = st_r.mem[addr_in];
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_out = st_r.rdata;
endmodule

// File: tb/hid_usb_partner.sv
// Behavioural far-side endpoint: sinks OUT words, sources IN words, ends each transaction
`timescale 1ns/10ps
module hid_usb_partner (
    input  wire logic        core_clk_in,
    input  wire logic        txn_start_in,
    input  wire logic        txn_is_in_in,
    input  wire logic        out_valid_in,
    input  wire logic [31:0] out_data_in,
    input  wire logic [3:0]  words_in,
    input  wire logic        slow_in,
    input  wire logic [3:0]  flags_in,
    output logic             out_ready_out,
    output logic             in_valid_out,
    output logic      [31:0] in_data_out,
    output logic             txn_done_out,
    output logic      [10:0] txn_bytes_out,
    output logic      [3:0]  flags_out,
    output logic      [31:0] rx_word_out
);
    int cnt;

    initial begin
        out_ready_out = 1'b0;
        in_valid_out  = 1'b0;
        in_data_out   = 32'h0000_0000;
        txn_done_out  = 1'b0;
        txn_bytes_out = 11'h000;
        flags_out     = 4'h0;
        rx_word_out   = 32'h0000_0000;
        forever begin
            @(posedge core_clk_in);
            if (txn_start_in) begin
                cnt = 0;
                while (cnt < int'(words_in)) begin
                    // Slow endpoint idles a cycle with a toggled data line
                    if (slow_in) begin
                        in_valid_out  <= 1'b0;
                        in_data_out   <= ~in_data_out;
                        out_ready_out <= 1'b0;
                        @(posedge core_clk_in);
                    end
                    if (txn_is_in_in) begin
                        in_valid_out <= 1'b1;
                        in_data_out  <= 32'hA5A5_0000 + 32'(cnt);
                        @(posedge core_clk_in);
                        cnt++;
                    end else begin
                        out_ready_out <= 1'b1;
                        @(posedge core_clk_in);
                        if (out_valid_in) begin
                            rx_word_out <= out_data_in;
                            cnt++;
                        end
                    end
                end
                in_valid_out  <= 1'b0;
                in_data_out   <= ~in_data_out;
                out_ready_out <= 1'b0;
                txn_done_out  <= 1'b1;
                txn_bytes_out <= {5'h00, words_in, 2'b00};
                flags_out     <= flags_in;
                @(posedge core_clk_in);
                txn_done_out  <= 1'b0;
                flags_out     <= 4'h0;
            end
        end
    end
endmodule

// File: tb/tb_hs_iso_descriptor_handler.sv
// Testbench for the isochronous descriptor engine
`timescale 1ns/10ps
module tb_hs_iso_descriptor_handler;
    import hid_pkg::*;
    logic        core_clk_in, rst_in, reg_write_in, reg_read_in, usb_usof_in;
    logic        out_ready_in, in_valid_in, txn_done_in, irq_out, txn_start_out;
    logic        txn_is_in_out, busy_out, out_valid_out, slow, last_in;
    logic [11:0] reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, out_data_out, in_data_in, rx_word, d;
    logic [10:0] usb_frame_in, txn_bytes_in;
    logic [2:0]  usb_uframe_in;
    logic [3:0]  words, flags, fl;
    int          error_cnt, n_tests, starts, i;

    hid_iso_engine i_hid_iso_engine (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
        .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out), .irq_out(irq_out),
        .usb_frame_in(usb_frame_in), .usb_uframe_in(usb_uframe_in), .usb_usof_in(usb_usof_in),
        .txn_start_out(txn_start_out), .txn_is_in_out(txn_is_in_out), .busy_out(busy_out),
        .out_valid_out(out_valid_out), .out_data_out(out_data_out),
        .out_ready_in(out_ready_in), .in_valid_in(in_valid_in), .in_data_in(in_data_in),
        .txn_done_in(txn_done_in), .txn_bytes_in(txn_bytes_in), .txn_err_in(fl[0]),
        .txn_babble_in(fl[1]), .txn_underrun_in(fl[2]), .txn_stall_in(fl[3]));

    hid_usb_partner i_hid_usb_partner (.core_clk_in(core_clk_in),
        .txn_start_in(txn_start_out), .txn_is_in_in(txn_is_in_out),
        .out_valid_in(out_valid_out), .out_data_in(out_data_out), .words_in(words),
        .slow_in(slow), .flags_in(flags), .out_ready_out(out_ready_in),
        .in_valid_out(in_valid_in), .in_data_out(in_data_in), .txn_done_out(txn_done_in),
        .txn_bytes_out(txn_bytes_in), .flags_out(fl), .rx_word_out(rx_word));

    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    always @(posedge core_clk_in) begin
        if (txn_start_out === 1'b1) begin
            starts  <= starts + 1;
            last_in <= txn_is_in_out;
        end
    end

    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        reg_addr_in  <= a;
        reg_wdata_in <= v;
        reg_write_in <= 1'b1;
        @(posedge core_clk_in);
        reg_write_in <= 1'b0;
        @(posedge core_clk_in);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        reg_addr_in <= a;
        reg_read_in <= 1'b1;
        @(posedge core_clk_in);
        reg_read_in <= 1'b0;
        #1 d = reg_rdata_out;
        @(posedge core_clk_in);
        chk("reg read", d, exp);
    endtask

    // One microframe start, then wait for the engine to go idle
    task automatic tick(input logic [2:0] uf, input logic [4:0] fr, input int exp);
        int s0, k;
        s0 = starts;
        usb_uframe_in <= uf;
        usb_frame_in  <= {6'h00, fr};
        usb_usof_in   <= 1'b1;
        @(posedge core_clk_in);
        usb_usof_in <= 1'b0;
        @(posedge core_clk_in);
        k = 0;
        do begin
            @(posedge core_clk_in);
            k++;
        end while (busy_out === 1'b1 && k < 200);
        if (busy_out !== 1'b0) begin
            error_cnt++;
            end_sim();
        end else begin
            @(posedge core_clk_in);
            chk("txn starts", 32'(starts - s0), 32'(exp));
        end
    endtask

    task automatic t_reset;
        rd(12'h00C, DW_RESET);
        rd(12'h010, DW_RESET);
        rd(REG_IRQ_STATUS, 32'h0000_0000);
        rd(12'h100, 32'h0000_0000);
    endtask

    task automatic t_out;
        for (i = 0; i < 4; i++) begin
            wr(PAYLOAD_BASE + 12'(8 * 16 + 4 * i), 32'hC0DE_0000 + 32'(i));
        end
        wr(12'h004, 32'h0000_0000);
        wr(12'h008, {8'h00, 16'h0010, 5'h0A, 3'b101});
        wr(12'h00C, 32'h8000_0000);
        wr(12'h010, 32'h0000_0055);
        wr(REG_IRQ_MASK, 32'h0000_0007);
        words = 4'h2;
        flags = 4'b0100;
        tick(3'h1, 5'h0A, 0);
        tick(3'h0, 5'h0B, 0);
        wr(12'h004, 32'h0000_0800);
        tick(3'h0, 5'h0A, 0);
        wr(12'h004, 32'h0000_0000);
        tick(3'h0, 5'h0A, 1);
        chk("direction", {31'h0, last_in}, 32'h0);
        chk("last out word", rx_word, 32'hC0DE_0001);
        rd(12'h010, 32'h0000_0454);
        chk("irq", {31'h0, irq_out}, 32'h1);
        rd(REG_IRQ_STATUS, 32'h0000_0005);
        chk("irq cleared", {31'h0, irq_out}, 32'h0);
        rd(12'h00C, 32'h8000_0008);
    endtask

    task automatic t_in;
        wr(12'h004, 32'h0000_0400);
        wr(12'h008, {8'h00, 16'h0020, 5'h03, 3'b000});
        wr(12'h00C, 32'hA000_7FF8);
        rd(12'h00C, 32'h8000_7FF8);
        wr(12'h010, 32'h0000_0080);
        words = 4'h3;
        slow  = 1'b1;
        flags = 4'b0010;
        tick(3'h7, 5'h03, 1);
        chk("direction", {31'h0, last_in}, 32'h1);
        rd(12'h010, 32'h4000_0000);
        rd(12'h00C, 32'h8000_7FFF);
        for (i = 0; i < 3; i++) begin
            rd(PAYLOAD_BASE + 12'(8 * 32 + 4 * i), 32'hA5A5_0000 + 32'(i));
        end
    endtask

    task automatic t_stall;
        rd(REG_IRQ_STATUS, 32'h0000_0005);
        wr(REG_IRQ_MASK, 32'h0000_0000);
        wr(12'h00C, 32'h8000_0000);
        wr(12'h010, 32'h0000_000C);
        words = 4'h1;
        flags = 4'b1000;
        tick(3'h2, 5'h03, 1);
        rd(12'h00C, 32'h4000_0004);
        chk("irq masked", {31'h0, irq_out}, 32'h0);
        tick(3'h3, 5'h03, 0);
        wr(REG_IRQ_MASK, 32'h0000_0007);
        chk("irq unmasked", {31'h0, irq_out}, 32'h1);
        rd(REG_IRQ_STATUS, 32'h0000_0003);
    endtask

    initial begin
        rst_in = 1'b1;
        {reg_write_in, reg_read_in, usb_usof_in, slow} = 4'h0;
        reg_addr_in = 12'h000;
        reg_wdata_in = 32'h0000_0000;
        usb_frame_in = 11'h000;
        usb_uframe_in = 3'h0;
        words = 4'h0;
        flags = 4'h0;
        {error_cnt, n_tests, starts} = {32'h0, 32'h0, 32'h0};
        last_in = 1'b0;
        repeat (4) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        t_reset();
        t_out();
        t_in();
        t_stall();
        end_sim();
    end
endmodule
